// [hw/dtc_pkg.sv]
// Package of constants and types for the dual timer/counter block
package dtc_pkg;

  // ****************************************************
  // Timing
  // ****************************************************
  // System clock (clk_sys) periods in one peripheral cycle
  localparam int PER_CLKS = 6;
  localparam logic [2:0] PER_LAST = 3'(PER_CLKS - 1);

  // ****************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************
  localparam logic [9:0] IDX_CTRL = 10'h088;
  localparam logic [9:0] IDX_MODE = 10'h089;
  localparam logic [9:0] IDX_C0_LO = 10'h08a;
  localparam logic [9:0] IDX_C1_LO = 10'h08b;
  localparam logic [9:0] IDX_C0_HI = 10'h08c;
  localparam logic [9:0] IDX_C1_HI = 10'h08d;
  localparam logic [9:0] IDX_IEN = 10'h0a8;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int CTL_TF1 = 7;
  localparam int CTL_TR1 = 6;
  localparam int CTL_TF0 = 5;
  localparam int CTL_TR0 = 4;
  localparam int CTL_IE1 = 3;
  localparam int CTL_IT1 = 2;
  localparam int CTL_IE0 = 1;
  localparam int CTL_IT0 = 0;
  localparam int MOD_COUNTER_ONE_PIN_GATING = 7;
  localparam int MOD_SRC1 = 6;
  localparam int MOD_M1 = 4;
  localparam int MOD_COUNTER_ZERO_PIN_GATING = 3;
  localparam int MOD_SRC0 = 2;
  localparam int MOD_M0 = 0;
  localparam int IEN_EA = 7;
  localparam int IEN_ET1 = 3;
  localparam int IEN_ET0 = 1;

  // Pin slots in the synchroniser vectors
  localparam int PIN_CNT0 = 0;
  localparam int PIN_CNT1 = 1;
  localparam int PIN_EXT_IRQ_ZERO_PIN = 2;
  localparam int PIN_EXT_IRQ_ONE_PIN = 3;

  // ****************************************************
  // Mode codes and reset values
  // ****************************************************
  localparam logic [1:0] MODE_PRESCALE = 2'b00;
  localparam logic [1:0] MODE_WIDE = 2'b01;
  localparam logic [1:0] MODE_RELOAD = 2'b10;
  localparam logic [1:0] MODE_SPLIT = 2'b11;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic ovf;
  } dtc_cnt_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] c0_lo;
    logic [7:0] c0_hi;
    logic [7:0] c1_lo;
    logic [7:0] c1_hi;
    logic [7:0] ien;
    logic [2:0] div;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_smp;
    logic wr_pend;
    logic [9:0] wr_idx;
    logic [31:0] hrdata;
    logic hready;
    logic irq0;
    logic irq1;
    logic baud;
    logic ovf0;
    logic ovf1;
  } dtc_state_t;

endpackage

// [hw/dtc_top.sv]
// Dual timer/counter with AHB-Lite register access
`timescale 1ns/1ps

module dtc_top
  import dtc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic count_input_zero_pin,
  input wire logic count_input_one_pin,
  input wire logic ext_irq_zero_pin_n,
  input wire logic ext_irq_one_pin_n,
  input wire logic counter_zero_irq_ack,
  input wire logic counter_one_irq_ack,
  input wire logic ext_irq_zero_ack,
  input wire logic ext_irq_one_ack,
  output logic counter_zero_irq,
  output logic counter_one_irq,
  output logic ext_irq_zero_req,
  output logic ext_irq_one_req,
  output logic counter_zero_overflow,
  output logic counter_one_overflow,
  output logic baud_tick
);

  // ****************************************************
  // Count step for modes 0 to 2
  // ****************************************************
  function automatic dtc_cnt_t step(input logic [1:0] m, input logic [7:0] lo,
                                    input logic [7:0] hi, input logic inc);
    dtc_cnt_t r;
    r.lo = lo;
    r.hi = hi;
    r.ovf = 1'b0;
    if (inc) begin
      case (m)
        MODE_PRESCALE: begin
          r.lo[4:0] = lo[4:0] + 5'h01;
          if (&lo[4:0]) begin
            r.hi = hi + 8'h01;
            r.ovf = &hi;
          end
        end
        MODE_WIDE: begin
          {r.hi, r.lo} = {hi, lo} + 16'h0001;
          r.ovf = &{hi, lo};
        end
        MODE_RELOAD: begin
          if (&lo) begin
            r.lo = hi;
            r.ovf = 1'b1;
          end else begin
            r.lo = lo + 8'h01;
          end
        end
        default: begin
          r.ovf = 1'b0;
        end
      endcase
    end
    return r;
  endfunction

  dtc_state_t q;
  dtc_state_t d;

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    logic tick;
    logic [3:0] fall;
    logic [1:0] m0;
    logic [1:0] m1;
    logic split;
    logic run0;
    logic run1;
    logic inc0;
    logic inc1;
    logic inc_hi;
    logic ovf_hi;
    logic addr_ok;
    logic [7:0] rd;
    logic [7:0] wb;
    dtc_cnt_t c0;
    dtc_cnt_t c1;
    d = q;
    tick = (q.div == PER_LAST);
    fall = 4'h0;
    m0 = q.mode[MOD_M0 +: 2];
    m1 = q.mode[MOD_M1 +: 2];
    split = (m0 == MODE_SPLIT);
    ovf_hi = 1'b0;
    rd = RST_BYTE;
    wb = hwdata[7:0];

    // Two-flop synchronisers, then one sample per peripheral cycle
    d.pin_s1 = {ext_irq_one_pin_n, ext_irq_zero_pin_n, count_input_one_pin,
                count_input_zero_pin};
    d.pin_s2 = q.pin_s1;
    d.div = tick ? 3'h0 : q.div + 3'h1;
    if (tick) begin
      d.pin_smp = q.pin_s2;
      fall = q.pin_smp & ~q.pin_s2;
    end

    // Gating and source selection
    run0 = q.ctrl[CTL_TR0] & (~q.mode[MOD_COUNTER_ZERO_PIN_GATING] | q.pin_s2[PIN_EXT_IRQ_ZERO_PIN]);
    // Run bit is lent to the split high byte, so counter one free-runs then
    run1 = (split | q.ctrl[CTL_TR1]) & (~q.mode[MOD_COUNTER_ONE_PIN_GATING] | q.pin_s2[PIN_EXT_IRQ_ONE_PIN]);
    inc0 = run0 & (q.mode[MOD_SRC0] ? fall[PIN_CNT0] : tick);
    inc1 = run1 & (q.mode[MOD_SRC1] ? fall[PIN_CNT1] : tick);
    inc_hi = split & q.ctrl[CTL_TR1] & tick;

    if (split) begin
      c0.lo = inc0 ? q.c0_lo + 8'h01 : q.c0_lo;
      c0.ovf = inc0 & (&q.c0_lo);
      c0.hi = inc_hi ? q.c0_hi + 8'h01 : q.c0_hi;
      ovf_hi = inc_hi & (&q.c0_hi);
    end else begin
      c0 = step(m0, q.c0_lo, q.c0_hi, inc0);
    end
    c1 = step(m1, q.c1_lo, q.c1_hi, inc1);
    d.c0_lo = c0.lo;
    d.c0_hi = c0.hi;
    d.c1_lo = c1.lo;
    d.c1_hi = c1.hi;
    d.ovf0 = c0.ovf;
    d.ovf1 = c1.ovf;
    d.baud = c1.ovf;

    // Register write in the data phase; a write wins over counting
    if (q.wr_pend) begin
      case (q.wr_idx)
        IDX_CTRL: d.ctrl = wb;
        IDX_MODE: d.mode = wb;
        IDX_C0_LO: d.c0_lo = wb;
        IDX_C0_HI: d.c0_hi = wb;
        IDX_C1_LO: d.c1_lo = wb;
        IDX_C1_HI: d.c1_hi = wb;
        IDX_IEN: d.ien = wb & 8'h8a;
        default: d.ien = d.ien;
      endcase
    end

    // Overflow flags: vector clear, hardware set wins
    if (counter_zero_irq_ack) begin
      d.ctrl[CTL_TF0] = 1'b0;
    end
    if (counter_one_irq_ack) begin
      d.ctrl[CTL_TF1] = 1'b0;
    end
    if (c0.ovf) begin
      d.ctrl[CTL_TF0] = 1'b1;
    end
    // Halted or free-running counter one in split mode raises no flag
    if (ovf_hi | (c1.ovf & ~split)) begin
      d.ctrl[CTL_TF1] = 1'b1;
    end

    // External interrupt flags
    if (q.ctrl[CTL_IT0]) begin
      if (ext_irq_zero_ack) begin
        d.ctrl[CTL_IE0] = 1'b0;
      end
      if (fall[PIN_EXT_IRQ_ZERO_PIN]) begin
        d.ctrl[CTL_IE0] = 1'b1;
      end
    end else begin
      d.ctrl[CTL_IE0] = ~q.pin_s2[PIN_EXT_IRQ_ZERO_PIN];
    end
    if (q.ctrl[CTL_IT1]) begin
      if (ext_irq_one_ack) begin
        d.ctrl[CTL_IE1] = 1'b0;
      end
      if (fall[PIN_EXT_IRQ_ONE_PIN]) begin
        d.ctrl[CTL_IE1] = 1'b1;
      end
    end else begin
      d.ctrl[CTL_IE1] = ~q.pin_s2[PIN_EXT_IRQ_ONE_PIN];
    end

    d.irq0 = d.ctrl[CTL_TF0] & d.ien[IEN_ET0] & d.ien[IEN_EA];
    d.irq1 = d.ctrl[CTL_TF1] & d.ien[IEN_ET1] & d.ien[IEN_EA];

    // ****************************************************
    // AHB-Lite address phase
    // ****************************************************
    addr_ok = hsel & htrans[1] & hready;
    d.wr_pend = addr_ok & hwrite;
    d.wr_idx = haddr[11:2];
    d.hready = 1'b1;
    case (haddr[11:2])
      IDX_CTRL: rd = q.ctrl;
      IDX_MODE: rd = q.mode;
      IDX_C0_LO: rd = q.c0_lo;
      IDX_C0_HI: rd = q.c0_hi;
      IDX_C1_LO: rd = q.c1_lo;
      IDX_C1_HI: rd = q.c1_hi;
      IDX_IEN: rd = q.ien;
      default: rd = RST_BYTE;
    endcase
    if (addr_ok & ~hwrite) begin
      d.hrdata = {24'h00_0000, rd};
    end
  end

  // ****************************************************
  // State register
  // ****************************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign hreadyout = q.hready;
  assign hresp = 1'b0 & q.hready;
  assign hrdata = q.hrdata;
  assign counter_zero_irq = q.irq0;
  assign counter_one_irq = q.irq1;
  assign ext_irq_zero_req = q.ctrl[CTL_IE0];
  assign ext_irq_one_req = q.ctrl[CTL_IE1];
  assign counter_zero_overflow = q.ovf0;
  assign counter_one_overflow = q.ovf1;
  assign baud_tick = q.baud;

endmodule

// [dv/dtc_top_sva.sv]
// Port assertions for the dual timer/counter
`timescale 1ns/1ps
module dtc_top_sva
  import dtc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic counter_zero_irq_ack,
  input wire logic counter_zero_irq,
  input wire logic counter_zero_overflow,
  input wire logic counter_one_overflow,
  input wire logic baud_tick,
  input wire logic ext_irq_zero_req
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ****************************************************
  // Bus
  // ****************************************************
  a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  a_ready_high: assert property ($past(reset_n) |-> hreadyout) else $error("wait state seen");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h00_0000) else $error("hrdata upper set");
  a_rdata_hold: assert property (!(hsel && htrans[1] && !hwrite && hready) |=> $stable(hrdata))
    else $error("hrdata moved");
  // ****************************************************
  // Overflow and interrupt
  // ****************************************************
  a_baud_same: assert property (baud_tick == counter_one_overflow) else $error("baud mismatch");
  a_ovf_spacing: assert property (counter_zero_overflow |=> !counter_zero_overflow [*5])
    else $error("overflow too close");
  a_ovf1_pulse: assert property (counter_one_overflow |=> !counter_one_overflow)
    else $error("overflow one too long");
  a_ack_clear: assert property (counter_zero_irq_ack |=> !counter_zero_irq || counter_zero_overflow)
    else $error("irq kept after ack");
  c_ovf0: cover property (counter_zero_overflow);
  c_baud: cover property (baud_tick);
  c_ext_req: cover property (ext_irq_zero_req);
endmodule
bind dtc_top dtc_top_sva u_dtc_top_sva (.clk_sys, .reset_n, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .counter_zero_irq_ack, .counter_zero_irq, .counter_zero_overflow,
  .counter_one_overflow, .baud_tick, .ext_irq_zero_req);

// [dv/dtc_pin_model.sv]
// Model of the external count and interrupt pins
`timescale 1ns/1ps
module dtc_pin_model
  import dtc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic load,
  input wire logic [3:0] n_fall,
  input wire logic irq_low,
  output logic count_pin,
  output logic irq_pin_n
);
  logic [4:0] left;
  logic [4:0] ph;
  initial begin
    count_pin = 1'b1;
    left = 5'h00;
    ph = 5'h00;
  end
  assign irq_pin_n = ~irq_low;
  // Each level held three peripheral cycles so no level is missed
  always @(posedge clk_sys) begin
    if (load) begin
      left <= {n_fall, 1'b0};
      ph <= 5'h00;
    end else if (left != 5'h00) begin
      ph <= ph + 5'h01;
      if (ph == 5'(3 * PER_CLKS - 1)) begin
        count_pin <= ~count_pin;
        left <= left - 5'h01;
        ph <= 5'h00;
      end
    end
  end
endmodule

// [dv/dtc_top_bench.sv]
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ps
module dtc_top_bench;
  import dtc_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic ack0 = 1'b0;
  logic eack0 = 1'b0;
  logic load = 1'b0;
  logic irq_low = 1'b0;
  logic [3:0] n_fall = 4'h0;
  logic hready, hresp, cpin, ipin_n, irq0, irq1, ereq0, ereq1, ovf0, ovf1, baud;
  logic [31:0] hrdata, r;
  logic [7:0] a;
  int n_fail = 0;
  int tests_run = 0;
  logic [7:0] plo[4] = '{8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0] phi[4] = '{8'hff, 8'hff, 8'ha5, 8'h33};
  logic [7:0] elo[4] = '{8'he0, 8'h00, 8'ha5, 8'h00};
  logic [7:0] ehi[4] = '{8'h00, 8'h00, 8'ha5, 8'h33};
  always #25 clk_sys = ~clk_sys;
  dtc_top u_dtc_top (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .count_input_zero_pin(cpin),
    .count_input_one_pin(1'b1), .ext_irq_zero_pin_n(ipin_n), .ext_irq_one_pin_n(1'b1),
    .counter_zero_irq_ack(ack0), .counter_one_irq_ack(1'b0), .ext_irq_zero_ack(eack0),
    .ext_irq_one_ack(1'b0), .counter_zero_irq(irq0), .counter_one_irq(irq1),
    .ext_irq_zero_req(ereq0), .ext_irq_one_req(ereq1), .counter_zero_overflow(ovf0),
    .counter_one_overflow(ovf1), .baud_tick(baud));
  dtc_pin_model u_dtc_pin_model (.clk_sys(clk_sys), .load(load), .n_fall(n_fall),
    .irq_low(irq_low), .count_pin(cpin), .irq_pin_n(ipin_n));
  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task xfer(input logic [9:0] i, input logic w, input logic [7:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0_0000, i, 2'b00};
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    do @(posedge clk_sys); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task rdc(input string nm, input logic [9:0] i, input logic [7:0] e);
    xfer(i, 1'b0, 8'h00);
    chk(nm, r[7:0], e);
  endtask
  task ackp(input logic ext);
    @(posedge clk_sys);
    if (ext) eack0 <= 1'b1;
    else ack0 <= 1'b1;
    @(posedge clk_sys);
    eack0 <= 1'b0;
    ack0 <= 1'b0;
    @(negedge clk_sys);
  endtask
  task wait_ev(input logic sel);
    int k;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while ((sel ? baud : ovf0) !== 1'b1 && k < 400);
  endtask
  task summarize;
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    summarize;
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rdc("c0_lo", IDX_C0_LO, RST_BYTE);
    rdc("c0_hi", IDX_C0_HI, RST_BYTE);
    rdc("unmapped", 10'h0ff, 8'h00);
    for (int m = 0; m < 4; m++) begin
      xfer(IDX_MODE, 1'b1, {6'h00, 2'(m)});
      xfer(IDX_C0_LO, 1'b1, plo[m]);
      xfer(IDX_C0_HI, 1'b1, phi[m]);
      xfer(IDX_IEN, 1'b1, (m == 3) ? 8'h02 : 8'h82);
      xfer(IDX_CTRL, 1'b1, 8'h10);
      wait_ev(1'b0);
      chk("irq0", {7'h00, irq0}, {7'h00, m != 3});
      rdc("lo", IDX_C0_LO, elo[m]);
      rdc("hi", IDX_C0_HI, ehi[m]);
      ackp(1'b0);
      chk("irq0 ack", {7'h00, irq0}, 8'h00);
      xfer(IDX_CTRL, 1'b1, 8'h00);
    end
    xfer(IDX_MODE, 1'b1, 8'h01);
    xfer(IDX_C0_LO, 1'b1, 8'h00);
    xfer(IDX_CTRL, 1'b1, 8'h10);
    xfer(IDX_C0_LO, 1'b0, 8'h00);
    a = r[7:0];
    repeat (57) @(posedge clk_sys);
    rdc("rate", IDX_C0_LO, a + 8'h0a);
    xfer(IDX_CTRL, 1'b1, 8'h00);
    xfer(IDX_C0_LO, 1'b0, 8'h00);
    a = r[7:0];
    repeat (30) @(posedge clk_sys);
    rdc("stopped", IDX_C0_LO, a);
    xfer(IDX_MODE, 1'b1, 8'h0d);
    xfer(IDX_C0_LO, 1'b1, 8'h00);
    xfer(IDX_CTRL, 1'b1, 8'h11);
    n_fall <= 4'h3;
    load <= 1'b1;
    @(posedge clk_sys);
    load <= 1'b0;
    repeat (150) @(posedge clk_sys);
    rdc("events", IDX_C0_LO, 8'h03);
    irq_low <= 1'b1;
    load <= 1'b1;
    @(posedge clk_sys);
    load <= 1'b0;
    repeat (120) @(posedge clk_sys);
    rdc("gated", IDX_C0_LO, 8'h03);
    chk("edge flag", {7'h00, ereq0}, 8'h01);
    ackp(1'b1);
    chk("edge ack", {7'h00, ereq0}, 8'h00);
    xfer(IDX_CTRL, 1'b1, 8'h00);
    ackp(1'b1);
    repeat (4) @(negedge clk_sys);
    chk("level low", {7'h00, ereq0}, 8'h01);
    irq_low <= 1'b0;
    repeat (6) @(negedge clk_sys);
    chk("level high", {7'h00, ereq0}, 8'h00);
    xfer(IDX_MODE, 1'b1, 8'h20);
    xfer(IDX_C1_HI, 1'b1, 8'hfe);
    xfer(IDX_C1_LO, 1'b1, 8'hfe);
    xfer(IDX_CTRL, 1'b1, 8'h40);
    wait_ev(1'b1);
    chk("baud", {7'h00, baud}, 8'h01);
    rdc("c1_lo", IDX_C1_LO, 8'hfe);
    xfer(IDX_MODE, 1'b1, 8'h30);
    xfer(IDX_C1_LO, 1'b0, 8'h00);
    a = r[7:0];
    repeat (30) @(posedge clk_sys);
    rdc("halt", IDX_C1_LO, a);
    xfer(IDX_CTRL, 1'b1, 8'h00);
    xfer(IDX_MODE, 1'b1, 8'h10);
    xfer(IDX_C1_LO, 1'b1, 8'hff);
    xfer(IDX_C1_HI, 1'b1, 8'hff);
    xfer(IDX_IEN, 1'b1, 8'h88);
    xfer(IDX_CTRL, 1'b1, 8'h40);
    wait_ev(1'b1);
    chk("ovf1", {7'h00, ovf1}, 8'h01);
    chk("irq1", {7'h00, irq1}, 8'h01);
    chk("ext1 idle", {7'h00, ereq1}, 8'h00);
    chk("hresp", {7'h00, hresp}, 8'h00);
    rdc("c1_hi wrap", IDX_C1_HI, 8'h00);
    summarize;
  end
endmodule
